// File: logic/serial_line_pkg.sv
// constants and types for the second serial port and its line-mode control
package serial_line_pkg;
	localparam int ADDR_W = 10;
	localparam logic [9:0] CTRL_ADDR_0 = 10'h190;
	localparam logic [9:0] CTRL_ADDR_1 = 10'h290;
	localparam logic [9:0] CTRL_ADDR_2 = 10'h390;
	localparam logic [1:0] CTRL_SEL_0 = 2'h0;
	localparam logic [1:0] CTRL_SEL_1 = 2'h1;
	localparam int PARTY_BIT = 3;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [9:0] UART_BASE_0 = 10'h3F8;
	localparam logic [9:0] UART_BASE_1 = 10'h2F8;
	localparam logic [9:0] UART_BASE_2 = 10'h3E8;
	localparam logic [9:0] UART_BASE_3 = 10'h2E8;
	localparam logic [2:0] REG_DATA = 3'h0;
	localparam logic [2:0] REG_IER = 3'h1;
	localparam logic [2:0] REG_IIR = 3'h2;
	localparam logic [2:0] REG_LCR = 3'h3;
	localparam logic [2:0] REG_MCR = 3'h4;
	localparam logic [2:0] REG_LSR = 3'h5;
	localparam logic [2:0] REG_MSR = 3'h6;
	localparam logic [2:0] REG_SCR = 3'h7;
	localparam int LCR_DLAB = 7;
	localparam int LCR_BREAK = 6;
	localparam int LCR_EVEN = 4;
	localparam int LCR_PEN = 3;
	localparam int LCR_STOP = 2;
	localparam int MCR_DTR = 0;
	localparam int MCR_RTS = 1;
	localparam int MCR_OUT1 = 2;
	localparam int MCR_OUT2 = 3;
	localparam int MCR_LOOP = 4;
	localparam int FCR_EN = 0;
	localparam int FCR_RXCLR = 1;
	localparam int FCR_TXCLR = 2;
	localparam logic [7:0] IIR_NONE = 8'h01;
	localparam logic [7:0] IIR_FIFO = 8'hC0;
	localparam logic [15:0] DIV_RST = 16'h0001;
	localparam int FIFO_DEPTH = 16;
	localparam int RX_W = 10;
	localparam logic [3:0] OS_LAST = 4'hF;
	localparam logic [3:0] OS_MID = 4'h7;
	localparam logic [2:0] WLEN_BASE = 3'h4;
	localparam logic [2:0] BIT_TOP = 3'h7;
	localparam int PIN_W = 20;
	localparam logic [19:0] PIN_IDLE = 20'hF0000;
	typedef enum logic [4:0] {
		S_IDLE = 5'h01,
		S_START = 5'h02,
		S_DATA = 5'h04,
		S_PAR = 5'h08,
		S_STOP = 5'h10
	} line_state_t;
endpackage

// File: logic/serial_line_control.sv
// second serial port: uart, isa decode, line-mode control register and transceiver steering
//
// Behaviour
// RULE_01: after reset the differential port runs full duplex, separate receive and transmit pairs.
// RULE_02: party-line mode starts only when software sets bit 3 at 190H.
// RULE_03: control address strap moves that register to 190H, 290H or 390H.
// RULE_04: in party-line mode RTS drives the shared pair: transmit when asserted.
// RULE_05: after reset the shared transceiver receives, its driver off.
// RULE_06: port decodes at 3F8h, 2F8h, 3E8h or 2E8h, or disabled; bases never shared.
// RULE_07: a strap routes the port as RS232 or differential; RS232 initially.
// RULE_08: loop straps feed RTS back to CTS and DTR back to DSR.
// RULE_09: port behaves as a 16550-style uart with 16-byte transmit and receive FIFOs.
// RULE_10: control register bit 3 reads back as written, zero after reset.
`timescale 1ns/1ns

module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input logic clk,
	input logic rst_n,
	input logic flush,
	input logic in_valid,
	input logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	logic push;
	logic pop;

	assign in_ready = count_r != (AW+1)'(DEPTH);
	assign out_valid = count_r != '0;
	assign out_data = mem_r[rd_ptr_r];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_ff @(posedge clk)
	begin
		if (push)
			mem_r[wr_ptr_r] <= in_data;
	end

	// depth is a power of two, so the pointers wrap on their own
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end
		else if (flush)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_r <= wr_ptr_r + 1'h1;
			if (pop)
				rd_ptr_r <= rd_ptr_r + 1'h1;
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

module serial_line_control (
	input logic CORE_CLK,
	input logic RST_N,
	input logic [serial_line_pkg::ADDR_W-1:0] ISA_SA,
	input logic ISA_AEN,
	input logic ISA_IOR_N,
	input logic ISA_IOW_N,
	input logic [7:0] ISA_SD_IN,
	output logic [7:0] ISA_SD_OUT,
	output logic ISA_SD_OE,
	input logic [1:0] SER1_BASE_SEL,
	input logic SER1_ENABLE,
	input logic [1:0] SER2_BASE_SEL,
	input logic SER2_ENABLE,
	input logic [1:0] CONTROL_ADDRESS_STRAP,
	input logic PARTY_LINE_SELECT_STRAP,
	input logic LINE_MODE_STRAP,
	input logic RTS_CTS_LOOP_STRAP,
	input logic DTR_DSR_LOOP_STRAP,
	input logic RS232_RXD,
	output logic RS232_TXD,
	output logic RS232_RTS,
	input logic RS232_CTS,
	output logic RS232_DTR,
	input logic RS232_DSR,
	input logic RS232_DCD,
	input logic RS232_RI,
	output logic DIFF_TXD,
	output logic DIFF_TX_EN,
	input logic DIFF_BUS_IN,
	output logic DIFF_BUS_OUT,
	output logic DIFF_BUS_OE
);
	import serial_line_pkg::*;

	function automatic logic [9:0] uart_base(input logic [1:0] sel);
		case (sel)
			2'h0: uart_base = UART_BASE_0;
			2'h1: uart_base = UART_BASE_1;
			2'h2: uart_base = UART_BASE_2;
			default: uart_base = UART_BASE_3;
		endcase
	endfunction

	function automatic logic parity_of(input logic [7:0] data, input logic [1:0] wlen, input logic even);
		logic [7:0] mask;
		mask = 8'hFF >> (2'h3 - wlen);
		parity_of = (^(data & mask)) ^ ~even;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	logic [PIN_W-1:0] pin_raw, s1_r, s2_r, s3_r, lvl_r;
	logic ior_n, iow_n, rxd232, bus_in, cts_pin, dsr_pin, dcd_pin, ri_pin;
	logic party_strap, diff_strap, rts_loop, dtr_loop, en1, en2;
	logic [1:0] addr_strap, base1, base2;

	assign pin_raw = {ISA_IOR_N, ISA_IOW_N, RS232_RXD, DIFF_BUS_IN, RS232_CTS, RS232_DSR, RS232_DCD,
		RS232_RI, CONTROL_ADDRESS_STRAP, PARTY_LINE_SELECT_STRAP, LINE_MODE_STRAP, RTS_CTS_LOOP_STRAP,
		DTR_DSR_LOOP_STRAP, SER1_BASE_SEL, SER1_ENABLE, SER2_BASE_SEL, SER2_ENABLE};
	assign {ior_n, iow_n, rxd232, bus_in, cts_pin, dsr_pin, dcd_pin, ri_pin, addr_strap, party_strap,
		diff_strap, rts_loop, dtr_loop, base1, en1, base2, en2} = lvl_r;

	// a level moves only once the second and third stages agree
	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			s1_r <= PIN_IDLE;
			s2_r <= PIN_IDLE;
			s3_r <= PIN_IDLE;
			lvl_r <= PIN_IDLE;
		end
		else
		begin
			s1_r <= pin_raw;
			s2_r <= s1_r;
			s3_r <= s2_r;
			lvl_r <= (s2_r & s3_r) | (lvl_r & (s2_r ^ s3_r));
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// address and data are taken as settled by the time the filtered strobe edge shows
	logic ior_prev_r, iow_prev_r, rd_start, wr_start, rd_hit_r;
	logic ctrl_hit, uart_hit, port_on, dlab;
	logic [9:0] ctrl_addr, port_base;
	logic [2:0] ofs;
	logic [7:0] ctrl_r, lcr_r, scr_r, dll_r, dlm_r, rd_mux, lsr, msr;
	logic [3:0] ier_r;
	logic [4:0] mcr_r;
	logic fcr_en_r;

	assign rd_start = ior_prev_r & ~ior_n;
	assign wr_start = iow_prev_r & ~iow_n;
	assign ofs = ISA_SA[2:0];
	assign dlab = lcr_r[LCR_DLAB];

	always_comb
	begin
		case (addr_strap)
			CTRL_SEL_0: ctrl_addr = CTRL_ADDR_0;
			CTRL_SEL_1: ctrl_addr = CTRL_ADDR_1;
			default: ctrl_addr = CTRL_ADDR_2;
		endcase
	end

	assign ctrl_hit = ~ISA_AEN & (ISA_SA == ctrl_addr); // RULE_03
	// a function result cannot be part-selected, so the base is held on a net
	assign port_base = uart_base(base2);
	assign port_on = en2 & ~(en1 & (uart_base(base1) == port_base)); // RULE_06
	assign uart_hit = ~ISA_AEN & port_on & (ISA_SA[9:3] == port_base[9:3]); // RULE_06

	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
			ctrl_r <= CTRL_RST;
		else if (wr_start & ctrl_hit)
			ctrl_r <= ISA_SD_IN; // RULE_10
	end

	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			ier_r <= '0;
			lcr_r <= '0;
			mcr_r <= '0;
			scr_r <= '0;
			dll_r <= DIV_RST[7:0];
			dlm_r <= DIV_RST[15:8];
			fcr_en_r <= '0;
		end
		else if (wr_start & uart_hit)
		begin
			case (ofs)
				REG_DATA: if (dlab) dll_r <= ISA_SD_IN;
				REG_IER: if (dlab) dlm_r <= ISA_SD_IN; else ier_r <= ISA_SD_IN[3:0];
				REG_IIR: fcr_en_r <= ISA_SD_IN[FCR_EN];
				REG_LCR: lcr_r <= ISA_SD_IN;
				REG_MCR: mcr_r <= ISA_SD_IN[4:0];
				REG_SCR: scr_r <= ISA_SD_IN;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	logic tx_have, tx_room, tx_take, rx_have, rx_room, rx_push_r, rx_pe_r, rx_fe_r, oe_r;
	logic [7:0] tx_word, rx_word;
	logic [RX_W-1:0] rx_head;
	logic tx_push, rx_pop, tx_flush, rx_flush, lsr_read, msr_read, tx_idle;

	assign tx_push = wr_start & uart_hit & (ofs == REG_DATA) & ~dlab;
	assign rx_pop = rd_start & uart_hit & (ofs == REG_DATA) & ~dlab;
	assign tx_flush = wr_start & uart_hit & (ofs == REG_IIR) & ISA_SD_IN[FCR_TXCLR];
	assign rx_flush = wr_start & uart_hit & (ofs == REG_IIR) & ISA_SD_IN[FCR_RXCLR];
	assign lsr_read = rd_start & uart_hit & (ofs == REG_LSR);
	assign msr_read = rd_start & uart_hit & (ofs == REG_MSR);

	// a write to a full transmit FIFO is dropped, as on the classic part
	byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) tx_fifo ( // RULE_09
		.clk(CORE_CLK), .rst_n(RST_N), .flush(tx_flush),
		.in_valid(tx_push & tx_room), .in_data(ISA_SD_IN), .in_ready(tx_room),
		.out_valid(tx_have), .out_data(tx_word), .out_ready(tx_take));

	byte_fifo #(.WIDTH(RX_W), .DEPTH(FIFO_DEPTH)) rx_fifo ( // RULE_09
		.clk(CORE_CLK), .rst_n(RST_N), .flush(rx_flush),
		.in_valid(rx_push_r), .in_data({rx_fe_r, rx_pe_r, rx_word}), .in_ready(rx_room),
		.out_valid(rx_have), .out_data(rx_head), .out_ready(rx_pop));

	////////////////////////////////////////////////////////////////////////////////
	logic rts, dtr, cts_eff, dsr_eff, dcd_eff, ri_eff, loop_on;
	logic [3:0] msr_prev_r, delta_r, msr_now;

	assign rts = mcr_r[MCR_RTS];
	assign dtr = mcr_r[MCR_DTR];
	assign loop_on = mcr_r[MCR_LOOP];
	assign cts_eff = loop_on ? rts : (rts_loop ? rts : cts_pin); // RULE_08
	assign dsr_eff = loop_on ? dtr : (dtr_loop ? dtr : dsr_pin); // RULE_08
	assign ri_eff = loop_on ? mcr_r[MCR_OUT1] : ri_pin;
	assign dcd_eff = loop_on ? mcr_r[MCR_OUT2] : dcd_pin;
	assign msr_now = {dcd_eff, ri_eff, dsr_eff, cts_eff};

	// a change in the read cycle itself survives the clear
	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			msr_prev_r <= '0;
			delta_r <= '0;
			oe_r <= '0;
			ior_prev_r <= '1;
			iow_prev_r <= '1;
		end
		else
		begin
			msr_prev_r <= msr_now;
			delta_r <= (delta_r & ~{4{msr_read}}) | ((msr_now ^ msr_prev_r) & {2'h3, 2'h3})
				& {1'h1, ~msr_now[2], 2'h3};
			oe_r <= (rx_push_r & ~rx_room) | (oe_r & ~lsr_read);
			ior_prev_r <= ior_n;
			iow_prev_r <= iow_n;
		end
	end

	assign lsr = {1'h0, tx_idle & ~tx_have, ~tx_have, 1'h0, rx_have & rx_head[9], rx_have & rx_head[8],
		oe_r, rx_have};
	assign msr = {msr_now, delta_r};

	always_comb
	begin
		rd_mux = '0;
		if (ctrl_hit)
			rd_mux = ctrl_r; // RULE_10
		else
			case (ofs)
				REG_DATA: rd_mux = dlab ? dll_r : rx_head[7:0];
				REG_IER: rd_mux = dlab ? dlm_r : {4'h0, ier_r};
				REG_IIR: rd_mux = IIR_NONE | (fcr_en_r ? IIR_FIFO : 8'h00);
				REG_LCR: rd_mux = lcr_r;
				REG_MCR: rd_mux = {3'h0, mcr_r};
				REG_LSR: rd_mux = lsr;
				REG_MSR: rd_mux = msr;
				default: rd_mux = scr_r;
			endcase
	end

	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			ISA_SD_OUT <= '0;
			rd_hit_r <= '0;
		end
		else if (rd_start)
		begin
			ISA_SD_OUT <= rd_mux;
			rd_hit_r <= ctrl_hit | uart_hit;
		end
		else if (ior_n)
			rd_hit_r <= '0;
	end

	assign ISA_SD_OE = rd_hit_r & ~ior_n;

	////////////////////////////////////////////////////////////////////////////////
	logic [15:0] div_cnt_r;
	logic tick;
	logic [2:0] wlen_last;

	assign tick = div_cnt_r == '0;
	assign wlen_last = WLEN_BASE + {1'h0, lcr_r[1:0]};

	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
			div_cnt_r <= '0;
		else
			div_cnt_r <= tick ? ({dlm_r, dll_r} - 16'h0001) : (div_cnt_r - 16'h0001);
	end

	line_state_t tx_state_r, rx_state_r;
	logic [3:0] tx_os_r, rx_os_r;
	logic [2:0] tx_bit_r, rx_bit_r;
	logic [7:0] tx_shift_r, rx_shift_r;
	logic txd_r, tx_par_r, tx_stop2_r, tx_last, rx_src, rx_sample;

	assign tx_idle = tx_state_r == S_IDLE;
	assign tx_take = tx_idle;
	assign tx_last = tick & (tx_os_r == OS_LAST);

	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			tx_state_r <= S_IDLE;
			tx_os_r <= '0;
			tx_bit_r <= '0;
			tx_shift_r <= '0;
			tx_par_r <= '0;
			tx_stop2_r <= '0;
			txd_r <= '1;
		end
		else
		begin
			tx_os_r <= tx_idle ? 4'h0 : (tx_os_r + {3'h0, tick});
			case (tx_state_r)
				S_IDLE:
				begin
					txd_r <= '1;
					if (tx_have)
					begin
						tx_shift_r <= tx_word;
						tx_par_r <= parity_of(tx_word, lcr_r[1:0], lcr_r[LCR_EVEN]);
						tx_stop2_r <= lcr_r[LCR_STOP];
						tx_bit_r <= '0;
						txd_r <= '0;
						tx_state_r <= S_START;
					end
				end
				S_START:
					if (tx_last)
					begin
						txd_r <= tx_shift_r[0];
						tx_state_r <= S_DATA;
					end
				S_DATA:
					if (tx_last)
					begin
						if (tx_bit_r == wlen_last)
						begin
							txd_r <= lcr_r[LCR_PEN] ? tx_par_r : 1'h1;
							tx_state_r <= lcr_r[LCR_PEN] ? S_PAR : S_STOP;
						end
						else
						begin
							tx_bit_r <= tx_bit_r + 3'h1;
							tx_shift_r <= tx_shift_r >> 1;
							txd_r <= tx_shift_r[1];
						end
					end
				S_PAR:
					if (tx_last)
					begin
						txd_r <= '1;
						tx_state_r <= S_STOP;
					end
				S_STOP:
					if (tx_last)
					begin
						if (tx_stop2_r)
							tx_stop2_r <= '0;
						else
							tx_state_r <= S_IDLE;
					end
				default: tx_state_r <= S_IDLE;
			endcase
		end
	end

	// own echo is masked while the shared pair is driven
	assign rx_src = loop_on ? (txd_r & ~lcr_r[LCR_BREAK]) : (diff_strap ? (bus_in | DIFF_BUS_OE) : rxd232);
	assign rx_sample = tick & (rx_os_r == OS_LAST);
	assign rx_word = rx_shift_r >> (BIT_TOP - wlen_last);

	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rx_state_r <= S_IDLE;
			rx_os_r <= '0;
			rx_bit_r <= '0;
			rx_shift_r <= '0;
			rx_pe_r <= '0;
			rx_fe_r <= '0;
			rx_push_r <= '0;
		end
		else
		begin
			rx_push_r <= '0;
			rx_os_r <= (rx_state_r == S_IDLE) ? 4'h0 : (rx_os_r + {3'h0, tick});
			case (rx_state_r)
				S_IDLE:
					if (!rx_src)
					begin
						rx_pe_r <= '0;
						rx_bit_r <= '0;
						rx_state_r <= S_START;
					end
				S_START:
					if (tick && rx_os_r == OS_MID)
					begin
						rx_os_r <= '0;
						rx_state_r <= rx_src ? S_IDLE : S_DATA;
					end
				S_DATA:
					if (rx_sample)
					begin
						rx_shift_r <= {rx_src, rx_shift_r[7:1]};
						rx_bit_r <= rx_bit_r + 3'h1;
						if (rx_bit_r == wlen_last)
							rx_state_r <= lcr_r[LCR_PEN] ? S_PAR : S_STOP;
					end
				S_PAR:
					if (rx_sample)
					begin
						rx_pe_r <= rx_src != parity_of(rx_word, lcr_r[1:0], lcr_r[LCR_EVEN]);
						rx_state_r <= S_STOP;
					end
				S_STOP:
					if (rx_sample)
					begin
						rx_fe_r <= ~rx_src;
						rx_push_r <= '1;
						rx_state_r <= S_IDLE;
					end
				default: rx_state_r <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	logic party_on, line_tx;

	assign party_on = diff_strap & party_strap & ctrl_r[PARTY_BIT]; // RULE_02
	assign line_tx = loop_on | (txd_r & ~lcr_r[LCR_BREAK]);

	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			RS232_TXD <= '1;
			RS232_RTS <= '0;
			RS232_DTR <= '0;
			DIFF_TXD <= '1;
			DIFF_TX_EN <= '0;
			DIFF_BUS_OUT <= '1;
			DIFF_BUS_OE <= '0; // RULE_05
		end
		else
		begin
			RS232_TXD <= diff_strap | line_tx; // RULE_07
			RS232_RTS <= rts & ~loop_on;
			RS232_DTR <= dtr & ~loop_on;
			DIFF_TXD <= line_tx;
			DIFF_TX_EN <= diff_strap & ~party_on; // RULE_01
			DIFF_BUS_OUT <= line_tx;
			DIFF_BUS_OE <= party_on & rts & ~loop_on; // RULE_04
		end
	end
endmodule

// File: tb/serial_line_control_properties.sv
// concurrent checks on the second serial port line-mode control ports
`timescale 1ns/1ns
module serial_line_control_properties (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic [serial_line_pkg::ADDR_W-1:0] ISA_SA,
	input wire logic ISA_AEN,
	input wire logic ISA_IOR_N,
	input wire logic ISA_SD_OE,
	input wire logic [1:0] SER1_BASE_SEL,
	input wire logic SER1_ENABLE,
	input wire logic [1:0] SER2_BASE_SEL,
	input wire logic SER2_ENABLE,
	input wire logic [1:0] CONTROL_ADDRESS_STRAP,
	input wire logic LINE_MODE_STRAP,
	input wire logic RS232_TXD,
	input wire logic RS232_RTS,
	input wire logic DIFF_TX_EN,
	input wire logic DIFF_BUS_OUT,
	input wire logic DIFF_BUS_OE
);
	import serial_line_pkg::*;
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RST_N);
	////////////////////////////////
	// read strobe held long enough to pass the pin filter
	sequence s_rd(a, hit);
		($fell(ISA_IOR_N) && ISA_SA == a && !ISA_AEN && hit) ##1 (!ISA_IOR_N)[*5];
	endsequence
	chk_ctrl_read: assert property (s_rd(CTRL_ADDR_0, CONTROL_ADDRESS_STRAP == CTRL_SEL_0) |-> ISA_SD_OE)
		else $error("control read not answered");
	chk_ctrl_alt: assert property (s_rd(CTRL_ADDR_1, CONTROL_ADDRESS_STRAP == CTRL_SEL_1) |-> ISA_SD_OE)
		else $error("moved control read not answered");
	chk_ctrl_moved: assert property (s_rd(CTRL_ADDR_0, CONTROL_ADDRESS_STRAP != CTRL_SEL_0) |-> !ISA_SD_OE)
		else $error("old control address still answers");
	chk_oe_idle: assert property (ISA_IOR_N [*6] |-> !ISA_SD_OE)
		else $error("data bus driven without read");
	chk_clash_off: assert property ((SER1_ENABLE && SER2_ENABLE && SER1_BASE_SEL == SER2_BASE_SEL
		&& SER2_BASE_SEL == 2'h0 && ISA_SA[9:3] == UART_BASE_0[9:3]) [*8] |-> !ISA_SD_OE)
		else $error("port answers on a shared base");
	chk_reset_receive: assert property ($rose(RST_N) |-> !DIFF_BUS_OE && DIFF_BUS_OUT)
		else $error("shared pair driven after reset");
	chk_oe_rts: assert property (DIFF_BUS_OE |-> RS232_RTS || $past(RS232_RTS))
		else $error("shared pair driven without rts");
	chk_oe_txen: assert property ($rose(DIFF_BUS_OE) |-> !DIFF_TX_EN)
		else $error("transmit pair on in party mode");
	chk_txen_rs232: assert property ((!LINE_MODE_STRAP) [*6] |-> !DIFF_TX_EN)
		else $error("transmit pair on in rs232 mode");
	chk_txd_idle: assert property (LINE_MODE_STRAP [*6] |-> RS232_TXD)
		else $error("rs232 line moves in differential mode");
endmodule
////////////////////////////////
bind serial_line_control serial_line_control_properties u_serial_line_control_properties (
	.CORE_CLK(CORE_CLK), .RST_N(RST_N), .ISA_SA(ISA_SA), .ISA_AEN(ISA_AEN), .ISA_IOR_N(ISA_IOR_N),
	.ISA_SD_OE(ISA_SD_OE), .SER1_BASE_SEL(SER1_BASE_SEL), .SER1_ENABLE(SER1_ENABLE),
	.SER2_BASE_SEL(SER2_BASE_SEL), .SER2_ENABLE(SER2_ENABLE), .CONTROL_ADDRESS_STRAP(CONTROL_ADDRESS_STRAP),
	.LINE_MODE_STRAP(LINE_MODE_STRAP), .RS232_TXD(RS232_TXD), .RS232_RTS(RS232_RTS),
	.DIFF_TX_EN(DIFF_TX_EN), .DIFF_BUS_OUT(DIFF_BUS_OUT), .DIFF_BUS_OE(DIFF_BUS_OE));

// File: tb/serial_station.sv
// remote serial station: sends and receives 8n1 frames at 16 clocks a bit
`timescale 1ns/1ns
module serial_station (
	input wire logic clk,
	input wire logic send,
	input wire logic [7:0] send_byte,
	input wire logic line_in,
	output logic line_out,
	output logic [7:0] got_byte
);
	int i;
	int j;
	// idle mark level, as a pulled-up line
	initial line_out = 1'b1;
	always @(posedge clk)
	begin
		if (send)
		begin
			line_out <= 1'b0;
			repeat (16) @(posedge clk);
			for (i = 0; i < 8; i++)
			begin
				line_out <= send_byte[i];
				repeat (16) @(posedge clk);
			end
			line_out <= 1'b1;
			repeat (16) @(posedge clk);
		end
	end
	// samples mid-bit; a busy block ignores data edges inside the frame
	always @(negedge line_in)
	begin
		repeat (24) @(posedge clk);
		for (j = 0; j < 8; j++)
		begin
			got_byte[j] = line_in;
			repeat (16) @(posedge clk);
		end
	end
endmodule

// File: tb/tb_serial_line_control.sv
// self-checking bench for the second serial port line-mode control
`timescale 1ns/1ns
module tb_serial_line_control;
	import serial_line_pkg::*;
	logic core_clk = 1'b0, rst_n = 1'b0, aen = 1'b0, ior_n = 1'b1, iow_n = 1'b1;
	logic [9:0] sa = 10'h000, base = 10'h3F8;
	logic [7:0] sd_in = 8'h00, sbyte = 8'h00, sd_out, got;
	logic [1:0] s1_sel = 2'h1, s2_sel = 2'h0, ca_strap = 2'h0;
	logic s1_en = 1'b1, s2_en = 1'b1, party = 1'b0, lmode = 1'b0, rts_loop = 1'b0, dtr_loop = 1'b0, send = 1'b0;
	logic sd_oe, txd, rts, dtr, dtxd, dtxen, bout, boe, sline;
	int num_errors = 0, cmp_count = 0, cycles = 0;
	// strap codes 2 and 3 both pick the top address
	logic [9:0] ca [4] = '{CTRL_ADDR_0, CTRL_ADDR_1, CTRL_ADDR_2, CTRL_ADDR_2};
	logic [9:0] ub [4] = '{UART_BASE_0, UART_BASE_1, UART_BASE_2, UART_BASE_3};
	always #50 core_clk = ~core_clk;
	serial_line_control u_serial_line_control (.CORE_CLK(core_clk), .RST_N(rst_n), .ISA_SA(sa), .ISA_AEN(aen),
		.ISA_IOR_N(ior_n), .ISA_IOW_N(iow_n), .ISA_SD_IN(sd_in), .ISA_SD_OUT(sd_out), .ISA_SD_OE(sd_oe),
		.SER1_BASE_SEL(s1_sel), .SER1_ENABLE(s1_en), .SER2_BASE_SEL(s2_sel), .SER2_ENABLE(s2_en),
		.CONTROL_ADDRESS_STRAP(ca_strap), .PARTY_LINE_SELECT_STRAP(party), .LINE_MODE_STRAP(lmode),
		.RTS_CTS_LOOP_STRAP(rts_loop), .DTR_DSR_LOOP_STRAP(dtr_loop), .RS232_RXD(sline), .RS232_TXD(txd),
		.RS232_RTS(rts), .RS232_CTS(1'b0), .RS232_DTR(dtr), .RS232_DSR(1'b0), .RS232_DCD(1'b0), .RS232_RI(1'b0),
		.DIFF_TXD(dtxd), .DIFF_TX_EN(dtxen), .DIFF_BUS_IN(sline), .DIFF_BUS_OUT(bout), .DIFF_BUS_OE(boe));
	serial_station u_serial_station (.clk(core_clk), .send(send), .send_byte(sbyte),
		.line_in(lmode ? dtxd : txd), .line_out(sline), .got_byte(got));
	////////////////////////////////
	task automatic test_done();
		$display("errors %0d comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
		#5;
	endtask
	// fixed strobe length and gap, longer than the pin filter needs
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		sa = a;
		sd_in = d;
		iow_n = 1'b0;
		idle(6);
		iow_n = 1'b1;
		idle(6);
	endtask
	task automatic rd(input logic [9:0] a, output logic [8:0] v);
		sa = a;
		ior_n = 1'b0;
		repeat (6) @(posedge core_clk);
		#1 v = {sd_oe, sd_out};
		#4 ior_n = 1'b1;
		idle(6);
	endtask
	task automatic rdc(input logic [9:0] a, input logic [8:0] exp);
		logic [8:0] v;
		rd(a, v);
		chk(v, exp);
	endtask
	////////////////////////////////
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			num_errors++;
			test_done();
		end
	end
	initial
	begin
		logic [8:0] v;
		int i;
		repeat (12) @(posedge core_clk);
		#5 rst_n = 1'b1;
		idle(6);
		chk(9'(boe), 9'h000);
		chk(9'(bout), 9'h001);
		chk(9'(dtxen), 9'h000);
		rdc(ca[0], {1'b1, CTRL_RST});
		lmode = 1'b1;
		party = 1'b1;
		idle(8);
		chk(9'(dtxen), 9'h001);
		wr(base + 10'(REG_MCR), 8'h02);
		chk(9'(boe), 9'h000);
		wr(ca[0], 8'h08);
		chk(9'(boe), 9'h001);
		chk(9'(dtxen), 9'h000);
		rdc(ca[0], 9'h108);
		wr(base + 10'(REG_MCR), 8'h00);
		chk(9'(boe), 9'h000);
		wr(ca[0], 8'h00);
		chk(9'(dtxen), 9'h001);
		for (i = 0; i < 4; i++)
		begin
			ca_strap = 2'(i);
			idle(8);
			wr(ca[(i + 1) % 3], 8'h08);
			rdc(ca[i], 9'h100);
			wr(ca[i], 8'h08);
			rdc(ca[i], 9'h108);
			rd(ca[(i + 1) % 3], v);
			chk(9'(v[8]), 9'h000);
			wr(ca[i], 8'h00);
		end
		ca_strap = 2'h0;
		for (i = 0; i < 4; i++)
		begin
			s2_sel = 2'(i);
			s1_sel = 2'(i + 1);
			idle(8);
			wr(ub[i] + 10'(REG_SCR), 8'hA0 + 8'(i));
			rdc(ub[i] + 10'(REG_SCR), {1'b1, 8'hA0 + 8'(i)});
			s1_sel = 2'(i);
			idle(8);
			rd(ub[i] + 10'(REG_SCR), v);
			chk(9'(v[8]), 9'h000);
		end
		s1_sel = 2'h1;
		s2_sel = 2'h0;
		s2_en = 1'b0;
		idle(8);
		rd(base + 10'(REG_SCR), v);
		chk(9'(v[8]), 9'h000);
		s2_en = 1'b1;
		lmode = 1'b0;
		rts_loop = 1'b1;
		dtr_loop = 1'b1;
		idle(8);
		wr(base + 10'(REG_MCR), 8'h03);
		rd(base + 10'(REG_MSR), v);
		chk(v & 9'h130, 9'h130);
		wr(base + 10'(REG_MCR), 8'h00);
		rd(base + 10'(REG_MSR), v);
		chk(v & 9'h130, 9'h100);
		rts_loop = 1'b0;
		dtr_loop = 1'b0;
		idle(8);
		wr(base + 10'(REG_MCR), 8'h03);
		chk({7'h00, rts, dtr}, 9'h003);
		rd(base + 10'(REG_MSR), v);
		chk(v & 9'h130, 9'h100);
		wr(base + 10'(REG_LCR), 8'h03);
		wr(base + 10'(REG_IIR), 8'h07);
		rdc(base + 10'(REG_IIR), {1'b1, IIR_NONE | IIR_FIFO});
		for (i = 0; i < 2; i++)
		begin
			lmode = i[0];
			idle(8);
			wr(base, 8'h5A ^ 8'(i));
			idle(200);
			chk(9'(got), 9'h05A ^ 9'(i));
		end
		// one byte past the fifo depth must overrun
		for (i = 0; i < 17; i++)
		begin
			sbyte = 8'(i) + 8'h30;
			send = 1'b1;
			idle(1);
			send = 1'b0;
			idle(170);
		end
		rd(base + 10'(REG_LSR), v);
		chk(v & 9'h103, 9'h103);
		for (i = 0; i < 16; i++)
			rdc(base, {1'b1, 8'(i) + 8'h30});
		rd(base + 10'(REG_LSR), v);
		chk(v & 9'h101, 9'h100);
		// a reset in mid-run must drop party mode and free the shared pair
		wr(ca[0], 8'h08);
		chk(9'(boe), 9'h001);
		rst_n = 1'b0;
		idle(3);
		chk(9'(boe), 9'h000);
		rst_n = 1'b1;
		idle(6);
		chk({6'h00, boe, bout, dtxen}, 9'h003);
		chk({7'h00, rts, dtr}, 9'h000);
		rdc(ca[0], {1'b1, CTRL_RST});
		test_done();
	end
endmodule
